// file: hdl/che_encoder.sv
/*
 Code hopping transmitter: APB programming and status registers,
 nonvolatile key, serial, seed, sync and config, button sequencing,
 encryption and serial code word output.
 Assumes synchronous button and battery inputs and an APB master.
*/
`timescale 1ns/100ps
module che_encoder
   import che_pkg::*;
#(
   parameter int DEBOUNCE = DEBOUNCE_CYC,
   parameter logic [31:0] SHUTOFF = SHUTOFF_CYC,
   parameter int BITDIV = BIT_DIV
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [BTN_BITS-1:0] btn,
   input wire logic vlow,
   output logic tx_data,
   output logic tx_active,
   output logic led
);
   typedef struct packed {
      logic [KEY_BITS-1:0] key;
      logic [31:0] ser;
      logic [SEED_BITS-1:0] seed;
      logic [SYNC_BITS-1:0] sync;
      logic [31:0] cfg;
   } che_nv_t;

   typedef struct packed {
      che_state_t st;
      logic prog;
      logic chk_ok;
      logic [31:0] chk;
      logic [BTN_BITS-1:0] bsamp;
      logic [WORD_BITS-1:0] word;
      logic [WORD_BITS-1:0] shreg;
      logic [6:0] bitn;
      logic [19:0] div;
      logic [19:0] dcnt;
      logic [31:0] tcnt;
      logic start;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic txd;
      logic txa;
      logic led;
      logic held;
   } che_vol_t;

   typedef struct packed {
      che_nv_t nv;
      che_vol_t v;
   } che_st_t;

   che_st_t s_q;
   che_st_t s_d;
   che_cipher_if cif ();
   logic wr;
   logic rd;
   logic mapped;
   logic bit_en;
   logic abort;
   logic seed_frame;
   logic [SYNC_BITS-1:0] sync_nx;
   logic [HOP_BITS-1:0] plain;

   che_cipher u_cipher
   (
      .pclk(pclk),
      .presetn(presetn),
      .cif(cif)
   );

   assign cif.start = s_q.v.start;
   assign cif.key = s_q.nv.key;
   assign cif.din = (s_q.v.st == CHE_CHECK) ? 32'h00000000 : plain;

   always_comb
   begin
      s_d = s_q;
      s_d.v.start = 1'b0;
      wr = psel && penable && pwrite && s_q.v.ready;
      rd = psel && penable && !s_q.v.ready;
      mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_BTN);
      bit_en = (s_q.v.div == 20'(BITDIV - 1));
      // New buttons only; released ones are ignored while any stays held
      abort = (s_q.v.st == CHE_SEND || s_q.v.st == CHE_GAP) && ((btn & ~s_q.v.bsamp) != '0);
      seed_frame = (btn == BTN_SEED) && s_q.nv.cfg[CFG_SEED_EN];
      sync_nx = s_q.nv.sync + 16'h0001;
      plain = {s_q.v.bsamp, 2'b00, s_q.nv.ser[9:0], s_q.nv.sync};

      // APB slave: one wait state, answer registered
      s_d.v.ready = psel && penable && !s_q.v.ready;
      s_d.v.err = 1'b0;
      if (rd)
      begin
         s_d.v.err = !mapped;
         case (paddr)
            REG_CMD: s_d.v.rdata = {29'h0, s_q.v.chk_ok, s_q.v.st != CHE_IDLE, s_q.v.prog};
            REG_CFG: s_d.v.rdata = s_q.nv.cfg;
            REG_SER: s_d.v.rdata = s_q.nv.ser;
            REG_SEED_LO: s_d.v.rdata = s_q.nv.seed[31:0];
            REG_SEED_HI: s_d.v.rdata = {16'h0000, s_q.nv.seed[47:32]};
            REG_SYNC: s_d.v.rdata = {16'h0000, s_q.nv.sync};
            REG_CHECK: s_d.v.rdata = s_q.v.chk_ok ? s_q.v.chk : 32'h00000000;
            REG_BTN: s_d.v.rdata = {28'h0, s_q.v.bsamp};
            default: s_d.v.rdata = 32'h00000000;
         endcase
      end
      if (wr && paddr == REG_CMD)
      begin
         if (pwdata[CMD_ERASE] && s_q.v.st == CHE_IDLE)
         begin
            // Erase wipes all nonvolatile fields, so a key can never be probed in place
            s_d.nv = '0;
            s_d.v.prog = 1'b1;
            s_d.v.chk_ok = 1'b0;
         end
         else if (pwdata[CMD_COMMIT] && s_q.v.prog && s_q.v.st == CHE_IDLE)
         begin
            s_d.v.prog = 1'b0;
            s_d.v.st = CHE_CHECK;
            s_d.v.start = 1'b1;
         end
      end
      else if (wr && s_q.v.prog)
      begin
         // APB writes change nonvolatile fields only inside a programming sequence
         case (paddr)
            REG_CFG: s_d.nv.cfg = pwdata;
            REG_SER: s_d.nv.ser = pwdata;
            REG_SEED_LO: s_d.nv.seed[31:0] = pwdata;
            REG_SEED_HI: s_d.nv.seed[47:32] = pwdata[15:0];
            REG_SYNC: s_d.nv.sync = pwdata[15:0];
            REG_KEY0: s_d.nv.key[31:0] = pwdata;
            REG_KEY0 + 8'h04: s_d.nv.key[63:32] = pwdata;
            default: s_d.nv = s_q.nv;
         endcase
      end

      // Bit rate divider
      if (s_q.v.st == CHE_SEND || s_q.v.st == CHE_GAP)
         s_d.v.div = bit_en ? 20'h00000 : s_q.v.div + 20'h00001;
      else
         s_d.v.div = 20'h00000;
      if (s_q.v.st == CHE_SEND || s_q.v.st == CHE_GAP)
         s_d.v.tcnt = s_q.v.tcnt + 32'h00000001;

      case (s_q.v.st)
         CHE_IDLE:
         begin
            s_d.v.txd = 1'b0;
            s_d.v.txa = 1'b0;
            s_d.v.led = 1'b0;
            if (btn == '0)
               s_d.v.held = 1'b0;
            if (btn != '0 && !s_q.v.prog && !s_q.v.held)
            begin
               s_d.v.st = CHE_DEBOUNCE;
               s_d.v.dcnt = 20'h00000;
            end
         end
         CHE_DEBOUNCE:
         begin
            s_d.v.dcnt = s_q.v.dcnt + 20'h00001;
            if (btn == '0)
               s_d.v.st = CHE_IDLE;
            else if (s_q.v.dcnt == 20'(DEBOUNCE - 1))
            begin
               s_d.v.bsamp = btn;
               s_d.v.tcnt = 32'h00000000;
               if (seed_frame)
               begin
                  s_d.v.word = {1'b1, vlow, btn, s_q.nv.ser[11:0], s_q.nv.seed};
                  s_d.v.st = CHE_SEND;
                  s_d.v.shreg = {1'b1, vlow, btn, s_q.nv.ser[11:0], s_q.nv.seed};
                  s_d.v.bitn = 7'h00;
               end
               else
               begin
                  s_d.nv.sync = sync_nx;
                  s_d.v.st = CHE_ENCRYPT;
                  s_d.v.start = 1'b1;
               end
            end
         end
         CHE_ENCRYPT:
         begin
            if (cif.done)
            begin
               // Hopping low, then serial, buttons, battery and frame flag
               s_d.v.word = {1'b0, vlow, s_q.v.bsamp, s_q.nv.ser[SER_BITS-1:0], cif.dout};
               s_d.v.shreg = {1'b0, vlow, s_q.v.bsamp, s_q.nv.ser[SER_BITS-1:0], cif.dout};
               s_d.v.bitn = 7'h00;
               s_d.v.st = CHE_SEND;
            end
         end
         CHE_SEND:
         begin
            s_d.v.txa = 1'b1;
            s_d.v.led = 1'b1;
            s_d.v.txd = s_q.v.shreg[0];
            if (bit_en)
            begin
               s_d.v.shreg = {1'b0, s_q.v.shreg[WORD_BITS-1:1]};
               s_d.v.bitn = s_q.v.bitn + 7'h01;
               if (s_q.v.bitn == 7'(WORD_BITS - 1))
               begin
                  s_d.v.bitn = 7'h00;
                  s_d.v.st = CHE_GAP;
               end
            end
         end
         CHE_GAP:
         begin
            s_d.v.txd = 1'b0;
            s_d.v.txa = 1'b0;
            s_d.v.led = 1'b0;
            if (bit_en)
            begin
               s_d.v.bitn = s_q.v.bitn + 7'h01;
               if (s_q.v.bitn == 7'(GAP_BITS - 1))
               begin
                  s_d.v.bitn = 7'h00;
                  if (btn == '0)
                     s_d.v.st = CHE_IDLE;
                  else if (s_q.nv.ser[SER_SHUTOFF] && s_q.v.tcnt >= SHUTOFF)
                  begin
                     // Stuck button: stay quiet until every button is let go
                     s_d.v.st = CHE_IDLE;
                     s_d.v.held = 1'b1;
                  end
                  else
                  begin
                     s_d.v.shreg = s_q.v.word;
                     s_d.v.st = CHE_SEND;
                  end
               end
            end
         end
         CHE_CHECK:
         begin
            if (cif.done)
            begin
               s_d.v.chk = cif.dout;
               s_d.v.chk_ok = 1'b1;
               s_d.v.st = CHE_IDLE;
            end
         end
         default: s_d.v.st = CHE_IDLE;
      endcase
      if (abort)
      begin
         s_d.v.st = CHE_IDLE;
         s_d.v.txd = 1'b0;
         s_d.v.txa = 1'b0;
         s_d.v.led = 1'b0;
      end
   end

   // Nonvolatile part is deliberately left out of reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q.v <= '0;
      end
      else
      begin
         s_q.v <= s_d.v;
         s_q.nv <= s_d.nv;
      end
   end

   assign prdata = s_q.v.rdata;
   assign pready = s_q.v.ready;
   assign pslverr = s_q.v.err;
   assign tx_data = s_q.v.txd;
   assign tx_active = s_q.v.txa;
   assign led = s_q.v.led;

   // Refused at elaboration: the cycle counters are only 20 bits wide
   if (DEBOUNCE < 1 || DEBOUNCE > 1048575)
      $error("che_encoder: DEBOUNCE out of range");
   if (BITDIV < 1 || BITDIV > 1048575)
      $error("che_encoder: BITDIV out of range");
   if (WORD_BITS != HOP_BITS + FIX_BITS + 2 - 2 || FIX_BITS != SER_BITS + BTN_BITS + 2)
      $error("che_encoder: code word layout inconsistent");
endmodule // che_encoder

// file: shared/che_pkg.sv
/*
 Shared constants and types of the code hopping encoder: register map,
 code word layout, reset values and timing. Assumes a 100 MHz pclk.
*/
package che_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int SHUTOFF_S = 25;
   localparam logic [31:0] SHUTOFF_CYC = 32'(SHUTOFF_S) * 32'(CLK_HZ);
   localparam int BIT_DIV = 40_000;
   localparam int GAP_BITS = 16;
   localparam int WORD_BITS = 66;
   localparam int HOP_BITS = 32;
   localparam int SER_BITS = 28;
   localparam int FIX_BITS = 34;
   localparam int BTN_BITS = 4;
   localparam int SYNC_BITS = 16;
   localparam int SEED_BITS = 48;
   localparam int KEY_BITS = 64;
   localparam int ROUNDS = 528;
   localparam logic [31:0] NLF_TABLE = 32'h3A5C96E1;
   // Register byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_SER = 8'h08;
   localparam logic [7:0] REG_SEED_LO = 8'h0C;
   localparam logic [7:0] REG_SEED_HI = 8'h10;
   localparam logic [7:0] REG_SYNC = 8'h14;
   localparam logic [7:0] REG_KEY0 = 8'h18;
   localparam logic [7:0] REG_KEY3 = 8'h24;
   localparam logic [7:0] REG_CHECK = 8'h28;
   localparam logic [7:0] REG_BTN = 8'h2C;
   // Field positions
   localparam int CMD_ERASE = 0;
   localparam int CMD_COMMIT = 1;
   localparam int ST_PROG = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_CHECK = 2;
   localparam int CFG_SEED_EN = 0;
   localparam int SER_SHUTOFF = 31;
   localparam int POS_SER = 32;
   localparam int POS_BTN = 60;
   localparam int POS_VLOW = 64;
   localparam int POS_SEEDF = 65;
   localparam logic [BTN_BITS-1:0] BTN_SEED = 4'hF;
   localparam logic [31:0] CFG_RST = 32'h00000001;
   typedef enum logic [2:0] {
      CHE_IDLE, CHE_DEBOUNCE, CHE_ENCRYPT, CHE_SEND, CHE_GAP, CHE_CHECK
   } che_state_t;
endpackage : che_pkg

// file: shared/che_cipher_if.sv
/*
 Carrier between the encoder and its block cipher core.
 Assumes both ends share pclk.
*/
`timescale 1ns/100ps
interface che_cipher_if;
   logic start;
   logic [63:0] key;
   logic [31:0] din;
   logic busy;
   logic done;
   logic [31:0] dout;
   modport master (output start, output key, output din, input busy, input done, input dout);
   modport slave (input start, input key, input din, output busy, output done, output dout);
endinterface : che_cipher_if

// file: hdl/che_cipher.sv
/*
 Bit-serial nonlinear feedback block cipher, 32-bit block, 64-bit key.
 Assumes start is a one-cycle pulse given while not busy.
*/
`timescale 1ns/100ps
module che_cipher
   import che_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   che_cipher_if.slave cif
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [9:0] cnt;
      logic [31:0] y;
      logic [63:0] k;
   } che_cst_t;

   che_cst_t s_q;
   che_cst_t s_d;
   logic [4:0] idx;
   logic fb;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      idx = {s_q.y[31], s_q.y[26], s_q.y[20], s_q.y[9], s_q.y[1]};
      fb = s_q.y[0] ^ s_q.y[16] ^ s_q.k[0] ^ NLF_TABLE[idx];
      if (cif.start && !s_q.busy)
      begin
         s_d.busy = 1'b1;
         s_d.cnt = 10'(ROUNDS);
         s_d.y = cif.din;
         s_d.k = cif.key;
      end
      else if (s_q.busy)
      begin
         // One round a clock keeps the core tiny; done follows start by ROUNDS + 1 cycles
         s_d.y = {fb, s_q.y[31:1]};
         s_d.k = {s_q.k[0], s_q.k[63:1]};
         s_d.cnt = s_q.cnt - 10'h001;
         if (s_q.cnt == 10'h001)
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.k = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign cif.busy = s_q.busy;
   assign cif.done = s_q.done;
   assign cif.dout = s_q.y;

   // Refused at elaboration: the round counter is 10 bits wide
   if (ROUNDS < 1 || ROUNDS > 1023)
      $error("che_cipher: ROUNDS out of range");
endmodule // che_cipher

// file: testbench/che_chk.sv
/*
 Port checker of the code hopping encoder.
 Assumes one pclk domain and an active low presetn.
*/
`timescale 1ns/100ps
module che_chk
   import che_pkg::*;
#(
   parameter int DEBOUNCE = 4,
   parameter logic [31:0] SHUTOFF = 32'h000007D0,
   parameter int BITDIV = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [BTN_BITS-1:0] btn,
   input wire logic vlow,
   input wire logic tx_data,
   input wire logic tx_active,
   input wire logic led
);
   logic [15:0] run_q;
   logic [BTN_BITS-1:0] set_q;
   logic new_q;
   // Buttons seen before a word starts; a bit outside them is an abort cause
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 16'h0000;
         set_q <= '0;
         new_q <= 1'b0;
      end
      else
      begin
         run_q <= tx_active ? run_q + 16'h0001 : 16'h0000;
         if (!tx_active)
         begin
            set_q <= btn;
            new_q <= 1'b0;
         end
         else if (|(btn & ~set_q))
            new_q <= 1'b1;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   property p_wait;
      s_setup ##1 s_access |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   property p_one;
      pready |=> !pready;
   endproperty
   a_one: assert property (p_one) else $error("pready held");
   property p_err;
      pslverr |-> pready && !pwrite;
   endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_key;
      pready && !pwrite && paddr >= REG_KEY0 && paddr <= REG_KEY3 |-> prdata == 32'h0;
   endproperty
   a_key: assert property (p_key) else $error("key readable");
   property p_quiet;
      !tx_active |-> !tx_data && !led;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output outside word");
   property p_len;
      $fell(tx_active) |-> run_q == 16'(WORD_BITS * BITDIV) || new_q;
   endproperty
   a_len: assert property (p_len) else $error("word length wrong");
   property p_abort;
      tx_active && |(btn & ~set_q) |-> ##[1:2] !tx_active;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_cause;
      $rose(tx_active) |-> $past(btn, 2) != '0;
   endproperty
   a_cause: assert property (p_cause) else $error("word without button");
endmodule // che_chk
bind che_encoder che_chk #(.DEBOUNCE(DEBOUNCE), .SHUTOFF(SHUTOFF), .BITDIV(BITDIV)) chk_u
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .btn(btn),
   .vlow(vlow),
   .tx_data(tx_data),
   .tx_active(tx_active),
   .led(led)
);

// file: testbench/che_rx_model.sv
/*
 Receiver model: collects code words LSB first, learns one transmitter.
 Assumes BITDIV pclk cycles per bit; it cannot decrypt, so the hop
 stands in for the counter when rejecting replays.
*/
`timescale 1ns/100ps
module che_rx_model
   import che_pkg::*;
#(
   parameter int BITDIV = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tx_data,
   input wire logic tx_active,
   input wire logic learn,
   output logic [WORD_BITS-1:0] word_q,
   output int words_q,
   output logic [BTN_BITS-1:0] act_q
);
   logic [WORD_BITS-1:0] sh_q;
   int cnt_q;
   logic [SER_BITS-1:0] ser_q;
   logic [HOP_BITS-1:0] hop_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 0;
         words_q <= 0;
         act_q <= '0;
      end
      else if (tx_active)
      begin
         cnt_q <= cnt_q + 1;
         if (cnt_q % BITDIV == BITDIV / 2)
            sh_q <= {tx_data, sh_q[WORD_BITS-1:1]};
      end
      else
      begin
         cnt_q <= 0;
         if (learn)
         begin
            ser_q <= word_q[59:32];
            hop_q <= word_q[31:0];
         end
         // Cut words are dropped whole
         if (cnt_q == WORD_BITS * BITDIV)
         begin
            word_q <= sh_q;
            words_q <= words_q + 1;
            act_q <= '0;
            if (sh_q[59:32] == ser_q && sh_q[31:0] != hop_q)
            begin
               act_q <= sh_q[63:60];
               hop_q <= sh_q[31:0];
            end
         end
      end
   end
endmodule // che_rx_model

// file: testbench/che_encoder_bench.sv
/*
 Random self-checking bench of the code hopping encoder and receiver.
 Assumes short debounce, bit and shutoff counts for simulation.
*/
`timescale 1ns/100ps
module che_encoder_bench
   import che_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] btn = 4'h0;
   logic vlow = 1'b0;
   logic learn = 1'b0;
   logic [31:0] prdata, rd, ser, hop;
   logic pready, pslverr, tx_data, tx_active, led, er;
   logic [65:0] word_q, w2;
   logic [3:0] act_q, b;
   logic [47:0] seed;
   logic [15:0] sync;
   int words_q;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   always #5 pclk = ~pclk;
   che_encoder #(.DEBOUNCE(4), .SHUTOFF(32'h000007D0), .BITDIV(4)) dut_u
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .btn(btn),
      .vlow(vlow),
      .tx_data(tx_data),
      .tx_active(tx_active),
      .led(led)
   );
   che_rx_model #(.BITDIV(4)) rx_u
   (
      .pclk(pclk),
      .presetn(presetn),
      .tx_data(tx_data),
      .tx_active(tx_active),
      .learn(learn),
      .word_q(word_q),
      .words_q(words_q),
      .act_q(act_q)
   );
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [65:0] e, input logic [65:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle();
      do
         apb(1'b0, REG_CMD, 32'h0);
      while (rd[ST_BUSY] !== 1'b0);
   endtask
   task automatic upto(input logic want);
      int n0;
      int n;
      n0 = words_q;
      n = 0;
      // A word arrives, or tx_active rises, within a bounded wait
      while (n < 3000 && (want ? tx_active !== 1'b1 : words_q == n0))
      begin
         @(posedge pclk);
         n++;
      end
      total_checks++;
      if (n == 3000)
      begin
         errors++;
         $display("FAIL wait expected %0d seen timeout", want);
      end
   endtask
   task automatic prog(input logic [31:0] cfg, input logic [15:0] s, input logic sm);
      // sm arms the stuck-button shutoff held in the top serial bit
      ser = ($urandom & 32'h0FFFFFFF) | {sm, 31'h00000000};
      seed = 48'({$urandom, $urandom});
      sync = s;
      apb(1'b1, REG_CMD, 32'h1);
      apb(1'b1, REG_SER, ser);
      apb(1'b1, REG_SEED_LO, seed[31:0]);
      apb(1'b1, REG_SEED_HI, {16'h0, seed[47:32]});
      apb(1'b1, REG_SYNC, {16'h0, s});
      apb(1'b1, REG_KEY0, $urandom);
      apb(1'b1, REG_KEY0 + 8'h04, $urandom);
      apb(1'b1, REG_CFG, cfg);
      apb(1'b0, REG_CHECK, 32'h0);
      chk("check hidden", 66'(0), 66'(rd));
      apb(1'b1, REG_CMD, 32'h2);
      idle();
      apb(1'b0, REG_SER, 32'h0);
      chk("serial", 66'(ser), 66'(rd));
      apb(1'b0, REG_KEY0, 32'h0);
      chk("key read", 66'(0), 66'(rd));
   endtask
   task automatic press(input logic [3:0] k, input logic sf);
      logic v;
      v = 1'($urandom);
      vlow <= v;
      btn <= k;
      upto(1'b0);
      if (sf)
         chk("seed word", {1'b1, v, k, ser[11:0], seed}, word_q);
      else
         chk("code word", {1'b0, v, k, ser[27:0], word_q[31:0]}, word_q);
      if (!sf)
         sync = sync + 16'h0001;
      apb(1'b0, REG_SYNC, 32'h0);
      chk("sync", 66'(sync), 66'(rd));
      apb(1'b0, REG_BTN, 32'h0);
      chk("buttons", 66'(k), 66'(rd));
   endtask
   initial
   begin
      void'($urandom(32'h93073E7E));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      prog(32'h1, 16'hFFFF, 1'b0);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped", 66'(1), 66'(er));
      apb(1'b1, REG_SER, 32'h0);
      apb(1'b0, REG_SER, 32'h0);
      chk("locked serial", 66'(ser), 66'(rd));
      for (int i = 0; i < 4; i++)
      begin
         hop = word_q[31:0];
         b = 4'(1 + $urandom % 14);
         press(b, 1'b0);
         if (i > 0)
         begin
            chk("hop moves", 66'(1), 66'(word_q[31:0] != hop));
            chk("receiver act", 66'(b), 66'(act_q));
         end
         w2 = word_q;
         upto(1'b0);
         chk("repeat", w2, word_q);
         btn <= 4'h0;
         idle();
         learn <= (i == 0);
      end
      learn <= 1'b0;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_SYNC, 32'h0);
      chk("sync kept", 66'(sync), 66'(rd));
      press(4'hF, 1'b1);
      btn <= 4'h0;
      idle();
      btn <= 4'h1;
      upto(1'b1);
      btn <= 4'h3;
      repeat (3) @(posedge pclk);
      chk("abort", 66'(0), 66'(tx_active));
      btn <= 4'h0;
      idle();
      btn <= 4'h6;
      upto(1'b1);
      btn <= 4'h2;
      upto(1'b0);
      chk("kept buttons", 66'(6), 66'(word_q[63:60]));
      btn <= 4'h0;
      idle();
      prog(32'h0, 16'($urandom), 1'b1);
      press(4'hF, 1'b0);
      // Button stuck past the shutoff: the fob must fall quiet while it is held
      repeat (2600) @(posedge pclk);
      apb(1'b0, REG_CMD, 32'h0);
      chk("shutoff busy", 66'(0), 66'(rd[ST_BUSY]));
      chk("shutoff tx", 66'(0), 66'(tx_active));
      btn <= 4'h0;
      idle();
      give_verdict();
   end
endmodule // che_encoder_bench
